// *** scm_clk_if.sv ***
// carrier between controller and glitch-free clock switch
`timescale 1ns/1ps
interface scm_clk_if;
  logic              fast_lvl;
  logic              slow_lvl;
  logic [5:0]        div_cnt;
  scm_pkg::scm_div_t req_code;
  logic              gate;
  logic              sys_clk;
  logic              switching;
  modport ctrl (output fast_lvl, slow_lvl, div_cnt, req_code, gate,
                input sys_clk, switching);
  modport sw   (input fast_lvl, slow_lvl, div_cnt, req_code, gate,
                output sys_clk, switching);
endinterface : scm_clk_if

// *** scm_clk_sw.sv ***
// glitch-free system clock switch and divider tap select
`timescale 1ns/1ps
`include "scm_defs.svh"
module scm_clk_sw (
  input wire logic   mclk,
  input wire logic   rst_n,
  scm_clk_if.sw      cif
);
  scm_pkg::scm_sw_e  state_q;
  scm_pkg::scm_div_t act_q;
  logic              out_q;
  logic              gate_q;
  logic              lvl_act;
  logic              lvl_req;

  // ==========================================================
  // level of the candidate clock for one select code
  function automatic logic scm_lvl(input scm_pkg::scm_div_t code,
                                   input logic f, input logic s,
                                   input logic [5:0] d);
    logic r;
    r = f;
    if (code == `SCM_DIV_SLOW)
      r = s;
    else if (code != 3'h0)
      r = d[code - 3'h1];
    return r;
  endfunction : scm_lvl

  assign lvl_act = scm_lvl(act_q, cif.fast_lvl, cif.slow_lvl, cif.div_cnt);
  assign lvl_req = scm_lvl(cif.req_code, cif.fast_lvl, cif.slow_lvl,
                           cif.div_cnt);

  // gate changes only while the active clock is low
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      gate_q <= 1'b1;
    else if (!lvl_act)
      gate_q <= cif.gate;

  // [R19] no short pulse
  // leave old clock when low, take new one when it is low too
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      state_q <= scm_pkg::SCM_SW_FOLLOW;
      act_q   <= 3'h0;
      out_q   <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        scm_pkg::SCM_SW_FOLLOW:
        begin
          out_q <= lvl_act & gate_q;
          if (cif.req_code != act_q && !(lvl_act & gate_q))
            state_q <= scm_pkg::SCM_SW_HOLD;
        end
        scm_pkg::SCM_SW_HOLD:
        begin
          out_q <= 1'b0;
          if (!lvl_req)
          begin
            act_q   <= cif.req_code;
            state_q <= scm_pkg::SCM_SW_FOLLOW;
          end
        end
      endcase
    end

  assign cif.sys_clk   = out_q;
  assign cif.switching = (state_q == scm_pkg::SCM_SW_HOLD);
endmodule : scm_clk_sw

// *** scm_defs.svh ***
// register offsets, field positions, reset values and counts
`ifndef SCM_DEFS_SVH
`define SCM_DEFS_SVH
// ==========================================================
// register offsets
`define SCM_ADDR_SYS_CTRL  2'h0
`define SCM_ADDR_FRC_CTRL  2'h1
`define SCM_ADDR_FXT_CTRL  2'h2
`define SCM_ADDR_SXT_CTRL  2'h3
// ==========================================================
// system clock control fields
`define SCM_SYS_DIV_HI     7
`define SCM_SYS_DIV_LO     5
`define SCM_SYS_FAST_SRC   3
`define SCM_SYS_SLOW_SRC   2
`define SCM_SYS_FAST_KA    1
`define SCM_SYS_SLOW_KA    0
`define SCM_SYS_CTRL_RST   8'h00
`define SCM_DIV_SLOW       3'h7
// ==========================================================
// oscillator control fields
`define SCM_FRC_FREQ_HI    3
`define SCM_FRC_FREQ_LO    2
`define SCM_OSC_FLAG       1
`define SCM_OSC_EN         0
`define SCM_FXT_MODE       2
`define SCM_FRC_CTRL_RST   8'h01
`define SCM_FXT_CTRL_RST   8'h00
`define SCM_SXT_CTRL_RST   8'h00
`define SCM_SXT_SPEED_VAL  1'b1
// ==========================================================
// oscillator edges counted before a stable flag sets
`define SCM_STABLE_EDGES   64
`endif

// *** scm_pkg.sv ***
// types shared by the clock and mode controller
package scm_pkg;
  // ==========================================================
  // operating modes, one-hot
  typedef enum logic [5:0] {
    SCM_FAST       = 6'h01,
    SCM_SLOW       = 6'h02,
    SCM_SLEEP      = 6'h04,
    SCM_STBY_SLOW  = 6'h08,
    SCM_STBY_BOTH  = 6'h10,
    SCM_STBY_FAST  = 6'h20
  } scm_mode_e;
  // ==========================================================
  // clock switch states, one-hot
  typedef enum logic [1:0] {
    SCM_SW_FOLLOW = 2'h1,
    SCM_SW_HOLD   = 2'h2
  } scm_sw_e;
  typedef logic [2:0] scm_div_t;
endpackage : scm_pkg

// *** scm_top.sv ***
// system clock source, divider and operating mode controller
// Function
// [R1] system clock comes from fast clock or slow clock per divider select
// [R2] fast clock is the external fast crystal or internal fast RC
// [R3] slow clock is the external slow crystal or internal slow RC
// [R4] fast mode runs CPU from fast clock divided by 1 to 64
// [R5] leaving fast for slow, fast oscillator follows its own enable bit
// [R6] six modes: fast, slow, sleep and three standby variants
// [R7] divider code 111 runs CPU from the selected slow source
// [R8] stop with both keep-alive bits low: sleep, CPU and clocks stop
// [R9] in sleep the watchdog RC runs only while the watchdog is enabled
// [R10] stop with only slow keep-alive set keeps slow oscillator only
// [R11] stop with both keep-alive bits set keeps both oscillators
// [R12] stop with only fast keep-alive set keeps fast oscillator only
// [R13] fast source select 0 picks internal RC, 1 the crystal; reset 0
// [R14] codes 000 to 110 divide by 1 to 64, 111 picks slow clock
// [R15] RC enable clears stable flag then sets it; new frequency after flag
// [R16] software waits the switch delay before relying on the new clock
// [R17] standby keeps system clock only if its source is kept alive
// [R18] slow source select 0 picks internal RC, 1 the crystal
// [R19] clock switches never emit a pulse shorter than either period
`timescale 1ns/1ps
`include "scm_defs.svh"
module scm_top #(
  parameter int STABLE_EDGES = `SCM_STABLE_EDGES
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       halt_req,
  input  wire logic       wake_req,
  input  wire logic       wdt_enable,
  input  wire logic       int_fast_rc_osc,
  input  wire logic       ext_fast_crystal_osc,
  input  wire logic       ext_slow_crystal_osc,
  input  wire logic       int_slow_rc_osc,
  output logic            int_fast_rc_osc_on,
  output logic            ext_fast_crystal_osc_on,
  output logic            ext_slow_crystal_osc_on,
  output logic            int_slow_rc_osc_on,
  output logic      [1:0] fast_rc_freq,
  output logic            fast_crystal_mode,
  output logic            sys_clk,
  output logic            sys_clk_switching,
  output logic            fast_clock,
  output logic            slow_clock,
  output logic            watchdog_rc_clock,
  output logic            cpu_run,
  output logic      [5:0] op_mode
);
  localparam int CW = $clog2(STABLE_EDGES + 1);
  localparam logic [CW-1:0] STABLE_CNT = CW'(STABLE_EDGES);

  // ==========================================================
  // control registers
  scm_pkg::scm_div_t sysclk_divider_select_q;
  logic              fast_source_select_q;
  logic              slow_source_select_q;
  logic              fast_osc_keep_alive_q;
  logic              slow_osc_keep_alive_q;
  logic [1:0]        frc_freq_q;
  logic              frc_en_q;
  logic              fxt_mode_q;
  logic              fxt_en_q;
  logic              sxt_en_q;
  logic [7:0]        rdata_q;
  logic [3:0]        osc_on_q;
  logic [3:0]        restart;
  logic [3:0]        osc_lvl;
  logic [3:0]        osc_rise;
  logic [3:0]        osc_flag;
  logic [5:0]        div_cnt_q;
  logic              fast_prev_q;
  logic              fast_lvl;
  logic              slow_lvl;
  logic              fast_rc_stable_flag;
  logic              fast_clk_q;
  logic              slow_clk_q;
  logic              wdt_clk_q;
  logic              stopped;
  logic              fast_need;
  logic              slow_need;
  logic              sys_gate;
  logic              wr_sys;
  logic              wr_frc;
  logic              wr_fxt;
  logic              wr_sxt;
  scm_pkg::scm_mode_e mode_q;
  scm_pkg::scm_mode_e run_mode;

  scm_clk_if cif ();

  // ==========================================================
  // register writes
  assign wr_sys = reg_wr && reg_addr == `SCM_ADDR_SYS_CTRL;
  assign wr_frc = reg_wr && reg_addr == `SCM_ADDR_FRC_CTRL;
  assign wr_fxt = reg_wr && reg_addr == `SCM_ADDR_FXT_CTRL;
  assign wr_sxt = reg_wr && reg_addr == `SCM_ADDR_SXT_CTRL;

  // [R13] source select reset
  // system clock control fields, reset to fast RC undivided
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      sysclk_divider_select_q <=
        3'(`SCM_SYS_CTRL_RST >> `SCM_SYS_DIV_LO);
      fast_source_select_q  <= 1'(`SCM_SYS_CTRL_RST >> `SCM_SYS_FAST_SRC);
      slow_source_select_q  <= 1'(`SCM_SYS_CTRL_RST >> `SCM_SYS_SLOW_SRC);
      fast_osc_keep_alive_q <= 1'(`SCM_SYS_CTRL_RST >> `SCM_SYS_FAST_KA);
      slow_osc_keep_alive_q <= 1'(`SCM_SYS_CTRL_RST >> `SCM_SYS_SLOW_KA);
    end
    else if (wr_sys)
    begin
      sysclk_divider_select_q <=
        reg_wdata[`SCM_SYS_DIV_HI:`SCM_SYS_DIV_LO];
      fast_source_select_q  <= reg_wdata[`SCM_SYS_FAST_SRC];
      slow_source_select_q  <= reg_wdata[`SCM_SYS_SLOW_SRC];
      fast_osc_keep_alive_q <= reg_wdata[`SCM_SYS_FAST_KA];
      slow_osc_keep_alive_q <= reg_wdata[`SCM_SYS_SLOW_KA];
    end

  // oscillator control fields
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      frc_freq_q <= 2'(`SCM_FRC_CTRL_RST >> `SCM_FRC_FREQ_LO);
      frc_en_q   <= 1'(`SCM_FRC_CTRL_RST >> `SCM_OSC_EN);
      fxt_mode_q <= 1'(`SCM_FXT_CTRL_RST >> `SCM_FXT_MODE);
      fxt_en_q   <= 1'(`SCM_FXT_CTRL_RST >> `SCM_OSC_EN);
      sxt_en_q   <= 1'(`SCM_SXT_CTRL_RST >> `SCM_OSC_EN);
    end
    else
    begin
      if (wr_frc)
      begin
        frc_freq_q <= reg_wdata[`SCM_FRC_FREQ_HI:`SCM_FRC_FREQ_LO];
        frc_en_q   <= reg_wdata[`SCM_OSC_EN];
      end
      if (wr_fxt)
      begin
        fxt_en_q <= reg_wdata[`SCM_OSC_EN];
        if (!fxt_en_q)  // drive strength is frozen while running
          fxt_mode_q <= reg_wdata[`SCM_FXT_MODE];
      end
      if (wr_sxt)
        sxt_en_q <= reg_wdata[`SCM_OSC_EN];
    end

  // ==========================================================
  // register reads, data in the cycle after the strobe only
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      rdata_q <= 8'h00;
    else if (!reg_rd)
      rdata_q <= 8'h00;
    else
    begin
      unique case (reg_addr)
        `SCM_ADDR_SYS_CTRL:
          rdata_q <= {sysclk_divider_select_q, 1'b0,
                      fast_source_select_q, slow_source_select_q,
                      fast_osc_keep_alive_q, slow_osc_keep_alive_q};
        `SCM_ADDR_FRC_CTRL:
          rdata_q <= {4'h0, frc_freq_q, osc_flag[0], frc_en_q};
        `SCM_ADDR_FXT_CTRL:
          rdata_q <= {5'h00, fxt_mode_q, osc_flag[1], fxt_en_q};
        `SCM_ADDR_SXT_CTRL:
          rdata_q <= {5'h00, `SCM_SXT_SPEED_VAL, osc_flag[2], sxt_en_q};
      endcase
    end

  assign reg_rdata = rdata_q;

  // ==========================================================
  // operating mode
  assign run_mode = (sysclk_divider_select_q == `SCM_DIV_SLOW) ?
                    scm_pkg::SCM_SLOW : scm_pkg::SCM_FAST;
  assign stopped  = !(mode_q == scm_pkg::SCM_FAST ||
                      mode_q == scm_pkg::SCM_SLOW);

  // [R6] six modes
  // running modes track the divider; stop picks by keep-alive bits
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      mode_q <= scm_pkg::SCM_FAST;
    else if (stopped)
    begin
      if (wake_req)
        mode_q <= run_mode;
    end
    else if (halt_req)
    begin
      unique case ({fast_osc_keep_alive_q, slow_osc_keep_alive_q})
        // [R8] enter sleep
        2'b00: mode_q <= scm_pkg::SCM_SLEEP;
        // [R10] slow only
        2'b01: mode_q <= scm_pkg::SCM_STBY_SLOW;
        // [R11] both kept
        2'b11: mode_q <= scm_pkg::SCM_STBY_BOTH;
        // [R12] fast only
        2'b10: mode_q <= scm_pkg::SCM_STBY_FAST;
      endcase
    end
    else
      mode_q <= run_mode;

  assign cpu_run = !stopped;
  assign op_mode = mode_q;

  // ==========================================================
  // oscillator enables
  // [R5] own enable in slow mode
  // selected fast source forced on only in fast mode or when kept
  assign fast_need = stopped ? fast_osc_keep_alive_q :
                     (sysclk_divider_select_q != `SCM_DIV_SLOW);
  assign slow_need = stopped ? slow_osc_keep_alive_q : 1'b1;

  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      osc_on_q <= 4'h0;
    else
    begin
      osc_on_q[0] <= (!fast_source_select_q && fast_need) ||
                     (frc_en_q && !stopped);
      osc_on_q[1] <= (fast_source_select_q && fast_need) ||
                     (fxt_en_q && !stopped);
      osc_on_q[2] <= (slow_source_select_q && slow_need) ||
                     (sxt_en_q && !stopped);
      // [R9] watchdog RC in sleep
      osc_on_q[3] <= mode_q != scm_pkg::SCM_SLEEP || wdt_enable;
    end

  assign int_fast_rc_osc_on      = osc_on_q[0];
  assign ext_fast_crystal_osc_on = osc_on_q[1];
  assign ext_slow_crystal_osc_on = osc_on_q[2];
  assign int_slow_rc_osc_on      = osc_on_q[3];

  // ==========================================================
  // per oscillator synchroniser, edge detect and stable flag
  assign osc_lvl = {int_slow_rc_osc, ext_slow_crystal_osc,
                    ext_fast_crystal_osc, int_fast_rc_osc};
  // a new RC frequency restarts its settling
  assign restart = {3'h0, wr_frc &&
    reg_wdata[`SCM_FRC_FREQ_HI:`SCM_FRC_FREQ_LO] != frc_freq_q};

  for (genvar i = 0; i < 4; i++)
  begin : g_osc
    logic          s1_q;
    logic          s2_q;
    logic          s3_q;
    logic [CW-1:0] cnt_q;

    // two-flop synchroniser plus edge history
    always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n)
      begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
      end
      else
      begin
        s1_q <= osc_lvl[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
      end

    assign osc_rise[i] = s2_q && !s3_q;

    // [R15] flag clears then sets
    // count edges after enable; flag high once enough have arrived
    always_ff @(posedge mclk or negedge rst_n)
      if (!rst_n)
        cnt_q <= '0;
      else if (!osc_on_q[i] || restart[i])
        cnt_q <= '0;
      else if (osc_rise[i] && cnt_q != STABLE_CNT)
        cnt_q <= cnt_q + CW'(1);

    assign osc_flag[i] = (cnt_q == STABLE_CNT);
  end

  assign fast_rc_stable_flag = osc_flag[0];

  assign fast_rc_freq      = frc_freq_q;
  assign fast_crystal_mode = fxt_mode_q;

  // ==========================================================
  // fast and slow clock levels, only from stable sources
  // [R2] fast source
  assign fast_lvl = fast_source_select_q ?
                    (g_osc[1].s2_q && osc_flag[1]) :
                    (g_osc[0].s2_q && fast_rc_stable_flag);
  // [R3] slow source
  // [R18] zero picks RC
  assign slow_lvl = slow_source_select_q ?
                    (g_osc[2].s2_q && osc_flag[2]) :
                    (g_osc[3].s2_q && osc_flag[3]);

  // [R4] divide by 1 to 64
  // ripple of fast edges; bit k is fast clock over 2^(k+1)
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      fast_prev_q <= 1'b0;
      div_cnt_q   <= 6'h00;
    end
    else
    begin
      fast_prev_q <= fast_lvl;
      if (fast_lvl && !fast_prev_q)
        div_cnt_q <= div_cnt_q + 6'h01;
    end

  // peripheral clocks follow their oscillators while kept on
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
    begin
      fast_clk_q <= 1'b0;
      slow_clk_q <= 1'b0;
      wdt_clk_q  <= 1'b0;
    end
    else
    begin
      fast_clk_q <= fast_lvl && fast_need;
      // [R8] slow clock stops in sleep
      slow_clk_q <= slow_lvl && slow_need;
      wdt_clk_q  <= g_osc[3].s2_q && osc_on_q[3];
    end

  assign fast_clock        = fast_clk_q;
  assign slow_clock        = slow_clk_q;
  assign watchdog_rc_clock = wdt_clk_q;

  // ==========================================================
  // system clock path
  // [R17] standby gating
  // system clock survives a stop only if its source is kept alive
  always_comb
  begin
    sys_gate = 1'b1;
    if (mode_q == scm_pkg::SCM_SLEEP)
      sys_gate = 1'b0;
    else if (stopped)
      sys_gate = (sysclk_divider_select_q == `SCM_DIV_SLOW) ?
                 slow_osc_keep_alive_q : fast_osc_keep_alive_q;
  end

  // [R1] fast or slow select
  // [R14] code decode in switch
  // [R7] code 111 slow
  assign cif.fast_lvl = fast_lvl;
  assign cif.slow_lvl = slow_lvl;
  assign cif.div_cnt  = div_cnt_q;
  assign cif.req_code = sysclk_divider_select_q;
  assign cif.gate     = sys_gate;

  scm_clk_sw u_sw (
    .mclk  (mclk),
    .rst_n (rst_n),
    .cif   (cif.sw)
  );

  assign sys_clk           = cif.sys_clk;
  assign sys_clk_switching = cif.switching;
endmodule : scm_top

// *** scm_top_props.sv ***
// port-level checks for the clock and mode controller
`timescale 1ns/1ps
module scm_top_props (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       halt_req,
  input wire logic       wake_req,
  input wire logic       wdt_enable,
  input wire logic       int_fast_rc_osc_on,
  input wire logic       ext_fast_crystal_osc_on,
  input wire logic       ext_slow_crystal_osc_on,
  input wire logic       int_slow_rc_osc_on,
  input wire logic       sys_clk,
  input wire logic       sys_clk_switching,
  input wire logic       slow_clock,
  input wire logic       cpu_run,
  input wire logic [5:0] op_mode
);
  // ==========================================================
  // clocking and request sequences
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_halt;
    cpu_run && halt_req;
  endsequence
  sequence s_wake;
    !cpu_run && wake_req;
  endsequence
  sequence s_slow_wr;
    reg_wr && reg_addr == 2'h0 && reg_wdata[7:5] == 3'h7;
  endsequence
  // ==========================================================
  // properties
  property p_halt_stop;
    s_halt |=> !cpu_run;
  endproperty
  property p_wake_run;
    s_wake |=> cpu_run;
  endproperty
  property p_stop_hold;
    !cpu_run && !wake_req |=> $stable(op_mode);
  endproperty
  property p_slow_sel;
    s_slow_wr and (cpu_run && !halt_req) |-> ##[1:2] op_mode == 6'h02;
  endproperty
  property p_sleep_off;
    (op_mode == 6'h04)[*6] |-> $stable(slow_clock) && !int_fast_rc_osc_on
      && !ext_fast_crystal_osc_on && !ext_slow_crystal_osc_on;
  endproperty
  property p_sleep_wdt;
    (op_mode == 6'h04)[*2] |-> int_slow_rc_osc_on == wdt_enable;
  endproperty
  property p_stby_slow;
    (op_mode == 6'h08)[*2] |-> !int_fast_rc_osc_on && !ext_fast_crystal_osc_on;
  endproperty
  property p_stby_both;
    (op_mode == 6'h10)[*2] |-> (int_fast_rc_osc_on || ext_fast_crystal_osc_on)
      && (int_slow_rc_osc_on || ext_slow_crystal_osc_on);
  endproperty
  property p_stby_fast;
    (op_mode == 6'h20)[*2] |-> !ext_slow_crystal_osc_on
      && (int_fast_rc_osc_on || ext_fast_crystal_osc_on);
  endproperty
  property p_sw_low;
    sys_clk_switching |-> !sys_clk;
  endproperty
  a_halt_stop: assert property (p_halt_stop)
    else $error("halt did not stop the cpu");
  a_wake_run: assert property (p_wake_run)
    else $error("wake did not restart the cpu");
  a_stop_hold: assert property (p_stop_hold)
    else $error("stopped mode changed without wake");
  a_slow_sel: assert property (p_slow_sel)
    else $error("divider code 7 did not select slow mode");
  a_sleep_off: assert property (p_sleep_off)
    else $error("clock still running in sleep");
  a_sleep_wdt: assert property (p_sleep_wdt)
    else $error("watchdog rc state wrong in sleep");
  a_stby_slow: assert property (p_stby_slow)
    else $error("fast oscillator on in slow-only standby");
  a_stby_both: assert property (p_stby_both)
    else $error("oscillator off in both-kept standby");
  a_stby_fast: assert property (p_stby_fast)
    else $error("wrong oscillators in fast-only standby");
  a_sw_low: assert property (p_sw_low)
    else $error("system clock high during switch hold");
endmodule : scm_top_props

bind scm_top scm_top_props u_props (
  .mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .halt_req, .wake_req,
  .wdt_enable, .int_fast_rc_osc_on, .ext_fast_crystal_osc_on,
  .ext_slow_crystal_osc_on, .int_slow_rc_osc_on, .sys_clk,
  .sys_clk_switching, .slow_clock, .cpu_run, .op_mode
);

// *** tb.sv ***
// self-checking bench for the clock and mode controller
`timescale 1ns/1ps
module tb;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       halt_req = 1'b0;
  logic       wake_req = 1'b0;
  logic       wdt_enable = 1'b0;
  logic [3:0] osc_w = 4'h0;
  logic [7:0] reg_rdata;
  wire  [3:0] osc_on;
  logic       sys_clk;
  logic       sys_clk_switching;
  logic       cpu_run;
  logic [5:0] op_mode;
  logic [1:0] frq;
  logic       fxm;
  logic       fck;
  logic       wdc;
  int         hp [4] = '{4, 5, 20, 23};
  int         oc [4] = '{0, 0, 0, 0};
  int         bad_count = 0;
  int         checks_done = 0;
  int         cyc = 0;

  scm_top #(.STABLE_EDGES(4)) DUT (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .halt_req(halt_req), .wake_req(wake_req),
    .wdt_enable(wdt_enable), .int_fast_rc_osc(osc_w[0]),
    .ext_fast_crystal_osc(osc_w[1]), .ext_slow_crystal_osc(osc_w[2]),
    .int_slow_rc_osc(osc_w[3]), .int_fast_rc_osc_on(osc_on[0]),
    .ext_fast_crystal_osc_on(osc_on[1]),
    .ext_slow_crystal_osc_on(osc_on[2]), .int_slow_rc_osc_on(osc_on[3]),
    .fast_rc_freq(frq), .fast_crystal_mode(fxm), .sys_clk(sys_clk),
    .sys_clk_switching(sys_clk_switching), .fast_clock(fck),
    .slow_clock(), .watchdog_rc_clock(wdc), .cpu_run(cpu_run),
    .op_mode(op_mode)
  );

  // 40 MHz clock
  initial
  begin
    forever #12.5 mclk = ~mclk;
  end

  // oscillators toggle only while enabled, else sit low
  always @(posedge mclk)
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (osc_on[i] !== 1'b1)
      begin
        osc_w[i] <= 1'b0;
        oc[i] <= 0;
      end
      else if (oc[i] == hp[i] - 1)
      begin
        osc_w[i] <= ~osc_w[i];
        oc[i] <= 0;
      end
      else
        oc[i] <= oc[i] + 1;
    end
  end

  // hang guard
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  // ==========================================================
  // compare, bus and pulse helpers
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp

  task automatic cmp_per(input int g, input int e);
    checks_done++;
    if (g != e)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp_per

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr

  task automatic chk_rd(input logic [1:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    cmp(reg_rdata, e);
    @(posedge mclk);
  endtask : chk_rd

  task automatic pulse(input logic h);
    halt_req <= h;
    wake_req <= ~h;
    @(posedge mclk);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
    @(posedge mclk);
    #1;
  endtask : pulse

  // cycles between two system clock rises, after settling
  task automatic per(output int p);
    time t0;
    repeat (3) @(posedge sys_clk);
    t0 = $time;
    @(posedge sys_clk);
    p = int'(($time - t0) / 64'd25);
  endtask : per

  // ==========================================================
  // scenarios
  task automatic t_reset();
    cmp(8'(op_mode), 8'h01);
    cmp({5'h00, cpu_run, osc_on[0], osc_on[3]}, 8'h07);
    chk_rd(2'h0, 8'h00);
    chk_rd(2'h1, 8'h01);
    chk_rd(2'h3, 8'h04);
  endtask : t_reset

  task automatic t_regs();
    wr(2'h0, 8'h1C);
    chk_rd(2'h0, 8'h0C);
    wr(2'h0, 8'h00);
    wr(2'h2, 8'h05);
    wr(2'h2, 8'h01);
    chk_rd(2'h2, 8'h05);
    cmp({7'h00, fxm}, 8'h01);
    wr(2'h2, 8'h00);
  endtask : t_regs

  task automatic t_flag();
    repeat (150) @(posedge mclk);
    chk_rd(2'h1, 8'h03);
    wr(2'h1, 8'h05);
    cmp({6'h00, frq}, 8'h01);
    chk_rd(2'h1, 8'h05);
    repeat (150) @(posedge mclk);
    chk_rd(2'h1, 8'h07);
  endtask : t_flag

  task automatic t_modes();
    logic [1:0] ka;
    logic [5:0] em [4] = '{6'h04, 6'h08, 6'h20, 6'h10};
    for (int i = 0; i < 5; i++)
    begin
      ka = i[1:0];
      wdt_enable <= (i == 4);
      wr(2'h0, {6'h00, ka});
      pulse(1'b1);
      cmp(8'(op_mode), 8'(em[ka]));
      cmp({5'h00, cpu_run, osc_on[0], osc_on[3]},
          {5'h00, 1'b0, ka[1], ka != 2'h0 || i == 4});
      pulse(1'b1);
      cmp(8'(op_mode), 8'(em[ka]));
      cmp({7'h00, fck & ~ka[1]}, 8'h00);
      cmp({7'h00, wdc & (i == 0)}, 8'h00);
      repeat (3) @(posedge mclk);
      pulse(1'b0);
      pulse(1'b0);
      cmp(8'(op_mode), 8'h01);
    end
    wdt_enable <= 1'b0;
  endtask : t_modes

  task automatic t_clock();
    int p;
    for (int k = 0; k < 7; k++)
    begin
      wr(2'h0, {k[2:0], 5'h00});
      per(p);
      cmp_per(p, 8 << k);
    end
    wr(2'h0, 8'h08);
    per(p);
    cmp_per(p, 10);
    wr(2'h0, 8'hE0);
    per(p);
    cmp_per(p, 46);
    cmp(8'(op_mode), 8'h02);
    wr(2'h0, 8'hE4);
    per(p);
    cmp_per(p, 40);
    wr(2'h0, 8'h00);
  endtask : t_clock

  task automatic report_and_stop();
    if (bad_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  // main sequence
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    t_reset();
    t_regs();
    t_flag();
    t_modes();
    t_clock();
    report_and_stop();
  end
endmodule : tb
